// [wit_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wit_map.svh"
// What this block does
// - Reset clears mode register to zero
// - Clock is main divided 128 or sub
// - Interval codes zero-five give 2^4..2^9 periods
// - Run bit low holds counter cleared
// - Enable low clears prescaler and counter
// - Half-second interrupt from nominal clocks
// - Run clear alone keeps prescaler counting
// - Interval interrupt repeats every period
// - Counter starts after one prescaler period
// - Bit and byte writes; bits 3,2 zero
// - Two separate interrupt lines, shared prescaler
module wit_top #(
	parameter int PRE_W = `WIT_PRE_W,
	parameter int CNT_W = `WIT_CNT_W
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             main_osc_tick,
	input  wire logic             sub_osc_clk,
	input  wire logic             reg_wr,
	input  wire logic             reg_bit_wr,
	input  wire logic [15:0]      reg_addr,
	input  wire logic [2:0]       reg_bit_sel,
	input  wire wit_pkg::wit_byte_t reg_wdata,
	output wit_pkg::wit_byte_t    reg_rdata,
	output logic                  half_second_irq,
	output logic                  interval_irq
);
	import wit_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		WIT_IDLE  = 3'h1,  // Disabled, all cleared
		WIT_ALIGN = 3'h2,  // Waiting first prescaler period
		WIT_RUN   = 3'h4   // Counter may run
	} wit_fsm_t;

	typedef struct packed {
		wit_fsm_t        fsm;
		logic            watch_clk_select;
		wit_sel_t        interval_sel;
		logic            counter_run_ctrl;
		logic            watch_op_enable;
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] cnt;
		logic            wirq;
		logic            iirq;
		wit_byte_t       rdata;
	} wit_st_t;

	wit_st_t st_q;      // Registered state
	wit_st_t st_d;      // Next state
	logic    div_tick;  // Main clock over 128
	logic    sub_tick;  // Synchronised subsystem edge
	logic    wtick;     // Watch clock tick
	logic    hit;       // Register address decoded
	wit_byte_t mode_q;  // Current mode byte
	wit_byte_t mode_wr; // Byte after this write

	// ****************************************
	// Clock sources
	// ****************************************
	wit_prediv #(
		.W (`WIT_MAIN_DIV_W)
	) u_prediv (
		.clk      (clk),
		.resetn   (resetn),
		.ce       (ce),
		.tick_in  (main_osc_tick),
		.clr      (~st_q.watch_op_enable),
		.tick_out (div_tick)
	);

	// Subsystem clock comes from a pin, so it is synchronised first
	wit_edge u_sub (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.din    (sub_osc_clk),
		.rise   (sub_tick)
	);

	// Source mux
	assign wtick = st_q.watch_clk_select ? sub_tick : div_tick;

	// ****************************************
	// Register access
	// ****************************************
	assign hit = (reg_addr == `WIT_ADDR_MODE_CTRL);
	assign mode_q = {st_q.watch_clk_select, st_q.interval_sel, 2'b00,
		st_q.counter_run_ctrl, st_q.watch_op_enable};

	// Byte or single-bit merge; unimplemented bits drop out
	always_comb begin
		mode_wr = mode_q;
		if (reg_bit_wr) begin
			mode_wr[reg_bit_sel] = reg_wdata[0];
		end else if (reg_wr) begin
			mode_wr = reg_wdata;
		end
		mode_wr = mode_wr & `WIT_MODE_RD_MASK;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.wirq = 1'b0;
		st_d.iirq = 1'b0;
		st_d.rdata = mode_q & `WIT_MODE_RD_MASK;
		// Software update; codes six and seven are the writer's fault
		if (hit && (reg_wr || reg_bit_wr)) begin
			st_d.watch_clk_select = mode_wr[`WIT_BIT_CLK_SEL];
			st_d.interval_sel = mode_wr[`WIT_BIT_SEL_HI:`WIT_BIT_SEL_LO];
			st_d.counter_run_ctrl = mode_wr[`WIT_BIT_RUN];
			st_d.watch_op_enable = mode_wr[`WIT_BIT_EN];
		end
		if (!st_q.watch_op_enable) begin
			// Disabled: prescaler and counter cleared
			st_d.pre = '0;
			st_d.cnt = '0;
			st_d.fsm = WIT_IDLE;
		end else begin
			if (wtick) begin
				// Prescaler runs regardless of the run bit
				st_d.pre = st_q.pre + {{(PRE_W-1){1'b0}}, 1'b1};
				// Interval tap: low bits all ones ends the period
				if (&(st_q.pre | ~((PRE_W)'((1 << (`WIT_SEL_BASE + 32'(st_q.interval_sel))) - 1)))) begin
					st_d.iirq = 1'b1;
				end
			end
			case (st_q.fsm)
				WIT_IDLE: begin
					st_d.fsm = WIT_ALIGN;
				end
				WIT_ALIGN: begin
					// First full prescaler period is lost
					if (wtick && (&st_q.pre)) begin
						st_d.fsm = WIT_RUN;
					end
				end
				WIT_RUN: begin
					if (!st_q.counter_run_ctrl) begin
						st_d.cnt = '0;
					end else if (wtick && (&st_q.pre)) begin
						// 32 terminal counts give half a second at nominal rates
						st_d.cnt = st_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
						if (&st_q.cnt) begin
							st_d.wirq = 1'b1;
						end
					end
				end
				default: begin
					st_d.fsm = WIT_IDLE;
				end
			endcase
		end
	end

	// Registers, state reset to zero except fsm, which resets to WIT_IDLE
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.fsm <= WIT_IDLE;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign half_second_irq = st_q.wirq;
	assign interval_irq = st_q.iirq;
endmodule
`default_nettype wire

// [wit_map.svh]
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH
// ****************************************
// Register address and field layout
// ****************************************
`define WIT_ADDR_MODE_CTRL  16'hFF4A
`define WIT_MODE_RESET      8'h00
`define WIT_BIT_CLK_SEL     7
`define WIT_BIT_SEL_HI      6
`define WIT_BIT_SEL_LO      4
`define WIT_BIT_RUN         1
`define WIT_BIT_EN          0
`define WIT_MODE_RD_MASK    8'hF3
// ****************************************
// Divider and counter figures
// ****************************************
`define WIT_MAIN_DIV_W      7
`define WIT_PRE_W           9
`define WIT_CNT_W           5
`define WIT_SEL_BASE        4
`define WIT_SEL_MAX         3'h5
`endif

// [wit_pkg.sv]
`include "wit_map.svh"
package wit_pkg;
	// Interval select code, three bits
	typedef logic [2:0] wit_sel_t;
	// Register byte
	typedef logic [7:0] wit_byte_t;
endpackage

// [wit_edge.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Two-flop synchroniser with rise detector
// ****************************************
module wit_edge (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic din,
	output logic      rise
);
	// State of the synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} wit_edge_st_t;

	wit_edge_st_t st_q;  // Registered state
	wit_edge_st_t st_d;  // Next state

	// Next state; only s2 and s3 feed the detector
	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	// Registers, frozen while enable is low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign rise = ce & st_q.s2 & ~st_q.s3;
endmodule
`default_nettype wire

// [wit_prediv.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wit_map.svh"
// ****************************************
// Main clock divider by two to the W
// ****************************************
module wit_prediv #(
	parameter int W = `WIT_MAIN_DIV_W
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic tick_in,
	input  wire logic clr,
	output logic      tick_out
);
	// Divider state
	typedef struct packed {
		logic [W-1:0] cnt;
	} wit_div_st_t;

	wit_div_st_t st_q;  // Registered count
	wit_div_st_t st_d;  // Next count

	// Count main ticks; the carry is one tick of the slow clock
	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d.cnt = '0;
		end else if (tick_in) begin
			st_d.cnt = st_q.cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign tick_out = ce & ~clr & tick_in & (&st_q.cnt);
endmodule
`default_nettype wire

// [wit_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wit_map.svh"
// ****************************************
// Port checker
// ****************************************
module wit_chk (
	input wire logic               clk,
	input wire logic               resetn,
	input wire logic               ce,
	input wire logic               reg_wr,
	input wire logic               reg_bit_wr,
	input wire logic [15:0]        reg_addr,
	input wire wit_pkg::wit_byte_t reg_wdata,
	input wire wit_pkg::wit_byte_t reg_rdata,
	input wire logic               half_second_irq,
	input wire logic               interval_irq
);
	import wit_pkg::*;
	logic hit; // Write taken at this edge
	assign hit = ce && (reg_wr || reg_bit_wr) && reg_addr == `WIT_ADDR_MODE_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_rst; $rose(resetn) |-> reg_rdata == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_gap; reg_rdata[3:2] == 2'h0; endproperty
	a_gap: assert property (p_gap) else $error("bits 3 2");
	property p_wr; hit && !reg_bit_wr |-> ##2 reg_rdata == ($past(reg_wdata, 2) & `WIT_MODE_RD_MASK); endproperty
	a_wr: assert property (p_wr) else $error("byte write");
	// Readback may only move two edges after a taken write
	property p_hold; !hit |=> ##1 $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_off; !reg_rdata[0] [*2] |-> !interval_irq && !half_second_irq; endproperty
	a_off: assert property (p_off) else $error("irq disabled");
	property p_run; !reg_rdata[1] [*2] |-> !half_second_irq; endproperty
	a_run: assert property (p_run) else $error("watch stopped");
	property p_ivp; interval_irq |=> !interval_irq; endproperty
	a_ivp: assert property (p_ivp) else $error("interval pulse");
	property p_hsp; half_second_irq |=> !half_second_irq; endproperty
	a_hsp: assert property (p_hsp) else $error("watch pulse");
endmodule
bind wit_top wit_chk u_chk (.clk, .resetn, .ce, .reg_wr, .reg_bit_wr, .reg_addr, .reg_wdata,
	.reg_rdata, .half_second_irq, .interval_irq);
`default_nettype wire

// [tb_wit_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Watch timer bench
// ****************************************
module tb_wit_top;
	import wit_pkg::*;
	logic        clk, resetn, ce, main_osc_tick, sub_osc_clk, reg_wr, reg_bit_wr;
	logic        half_second_irq, interval_irq;
	logic [15:0] reg_addr;
	logic [2:0]  reg_bit_sel;
	wit_byte_t   reg_wdata, reg_rdata;
	logic [1:0]  sub_div;  // Sub pin period of four clocks keeps ticks regular
	logic [19:0] rows [8]; // Bit flag, bit, data, readback
	int          err_total, n_tests, t;
	// Short counter keeps the watch run small
	wit_top #(.PRE_W(9), .CNT_W(2)) uut (.clk, .resetn, .ce, .main_osc_tick, .sub_osc_clk,
		.reg_wr, .reg_bit_wr, .reg_addr, .reg_bit_sel, .reg_wdata, .reg_rdata,
		.half_second_irq, .interval_irq);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		sub_div <= sub_div + 2'h1;
		sub_osc_clk <= sub_div[1];
	end
	task automatic chk(input string s, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %0h got %0h", s, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One register write, byte or single bit
	task automatic w(input logic b, input logic [15:0] a, input logic [2:0] s, input wit_byte_t d);
		@(posedge clk);
		reg_wr <= !b;
		reg_bit_wr <= b;
		reg_addr <= a;
		reg_bit_sel <= s;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_bit_wr <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// Cycles until the chosen interrupt, bounded
	task automatic wt(input logic hs, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((hs ? half_second_irq : interval_irq) !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			err_total++;
			finish_test();
		end
	endtask
	initial begin
		{resetn, ce, main_osc_tick, sub_osc_clk, reg_wr, reg_bit_wr} = 6'h18;
		{reg_addr, reg_bit_sel, reg_wdata, sub_div, err_total, n_tests} = '0;
		// Interval codes six and seven are never written
		rows = '{20'h0DFD3, 20'h00C00, 20'h0A5A1, 20'hF0021,
			20'hB0121, 20'h80020, 20'hC0130, 20'h00000};
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk("reset", reg_rdata, 8'h00);
		foreach (rows[i]) begin
			w(rows[i][19], 16'hFF4A, rows[i][18:16], rows[i][15:8]);
			chk("readback", reg_rdata, rows[i][7:0]);
		end
		w(1'b0, 16'hFF4B, 3'h0, 8'hFF);
		chk("unmapped", reg_rdata, 8'h00);
		w(1'b0, 16'hFF4A, 3'h0, 8'h01);
		wt(1'b0, t);
		wt(1'b0, t);
		chk("main interval", t, 32'h800);
		for (int c = 0; c < 6; c++) begin
			w(1'b0, 16'hFF4A, 3'h0, {1'b1, c[2:0], 4'h1});
			wt(1'b0, t);
			wt(1'b0, t);
			chk("sub interval", t, 32'h40 << c);
		end
		w(1'b0, 16'hFF4A, 3'h0, 8'h00);
		w(1'b0, 16'hFF4A, 3'h0, 8'h83);
		wt(1'b1, t);
		chk("first watch", t > 32'h27EC && t < 32'h2814, 1'b1);
		wt(1'b1, t);
		chk("watch gap", t, 32'h2000);
		// Counter restarts without a new alignment wrap
		w(1'b1, 16'hFF4A, 3'h1, 8'h00);
		w(1'b1, 16'hFF4A, 3'h1, 8'h01);
		wt(1'b1, t);
		chk("run restart", t < 32'h2008, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		@(negedge clk);
		chk("mid reset", {reg_rdata, half_second_irq, interval_irq}, 10'h000);
		finish_test();
	end
endmodule
`default_nettype wire
